// [hw/eds_pkg.sv]
// Constants and types of the DMA event status block
// Summary of operation
// - Frame sent with completion request sets bit 0
// - Transmit process entering stop sets bit 1
// - Host-owned transmit descriptor suspends, sets bit 2
// - Jabber expiry stops transmit, sets bit 3
// - Receive overflow sets bit 4, marks descriptor only once a byte of the frame has been counted
// - Transmit underflow suspends, sets bit 5, marks descriptor
// - Received frame written back without overflow sets bit 6
// - Host-owned receive descriptor suspends, sets bit 7 only if the current descriptor is DMA-owned
// - Receive resumes on poll or next frame
// - Receive process entering stop sets bit 8
// - Frame longer than 2048 bytes sets bit 9
// - Whole frame in transmit FIFO sets bit 10
// - Bit 15 ORs enabled abnormal flags
// - Bit 16 ORs enabled normal flags
// - Transmit state shows 110 while suspended
package eds_pkg;
   localparam logic [15:0] OFF_TX_POLL = 16'h1004;
   localparam logic [15:0] OFF_RX_POLL = 16'h1008;
   localparam logic [15:0] OFF_STATUS = 16'h1014;
   localparam logic [15:0] OFF_ENABLE = 16'h101c;
   localparam int BIT_TX_DONE = 0;
   localparam int BIT_TX_STOP = 1;
   localparam int BIT_TX_UNAV = 2;
   localparam int BIT_JABBER = 3;
   localparam int BIT_RX_OVF = 4;
   localparam int BIT_TX_UNF = 5;
   localparam int BIT_RX_DONE = 6;
   localparam int BIT_RX_UNAV = 7;
   localparam int BIT_RX_STOP = 8;
   localparam int BIT_RX_WDOG = 9;
   localparam int BIT_TX_EARLY = 10;
   localparam int BIT_ABN_SUM = 15;
   localparam int BIT_NRM_SUM = 16;
   localparam int RX_STATE_LSB = 17;
   localparam int TX_STATE_LSB = 20;
   localparam int DESC_JABBER_BIT = 14;
   localparam int DESC_UNF_BIT = 1;
   localparam int DESC_OVF_BIT = 11;
   localparam int FLAG_W = 11;
   localparam logic [10:0] ABN_MASK = 11'h7ba;
   localparam logic [10:0] NRM_MASK = 11'h045;
   localparam logic [10:0] FLAGS_RESET = 11'h000;
   localparam logic [16:0] ENABLE_RESET = 17'h00000;
   localparam logic [11:0] RX_WDOG_BYTES = 12'h800;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [2:0] {
      TX_STOP = 3'b000,
      TX_FETCH = 3'b001,
      TX_READ = 3'b011,
      TX_SUSP = 3'b110,
      TX_CLOSE = 3'b111
   } eds_tx_state_t;
   typedef enum logic [2:0] {
      RX_STOP = 3'b000,
      RX_FETCH = 3'b001,
      RX_WAIT = 3'b011,
      RX_SUSP = 3'b100,
      RX_XFER = 3'b111
   } eds_rx_state_t;
endpackage : eds_pkg

// [hw/eds_stream_if.sv]
// Valid/ready word stream between the block's modules
`timescale 1ns/10ps
interface eds_stream_if #(parameter int WIDTH = 33);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : eds_stream_if

// [hw/eds_fifo.sv]
// Synchronous FIFO with registered output stage
`timescale 1ns/10ps
module eds_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side gate
   input wire logic allowIn,
   // Streams
   eds_stream_if.snk inPort,
   eds_stream_if.src outPort
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic [AW:0] nxt_count;
   logic inReady_ff;
   logic outValid_ff;
   logic [WIDTH-1:0] outData_ff;
   logic push;
   logic pop;

   assign push = inPort.valid && inReady_ff;
   assign pop = (count_ff != '0) && (!outValid_ff || outPort.ready);
   assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
   assign inPort.ready = inReady_ff;
   assign outPort.valid = outValid_ff;
   assign outPort.data = outData_ff;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= inPort.data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         inReady_ff <= 1'b0;
      end else begin
         wrPtr_ff <= wrPtr_ff + AW'(push);
         rdPtr_ff <= rdPtr_ff + AW'(pop);
         count_ff <= nxt_count;
         inReady_ff <= allowIn && (nxt_count < (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         outValid_ff <= 1'b0;
         outData_ff <= '0;
      end else if (pop) begin
         outValid_ff <= 1'b1;
         outData_ff <= mem[rdPtr_ff];
      end else if (outPort.ready) begin
         outValid_ff <= 1'b0;
      end
   end
endmodule : eds_fifo

// [hw/eth_dma_status_flags.sv]
// DMA event status flags, process states and transmit data FIFO
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module eth_dma_status_flags (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // Process control
   input wire logic txEnable,
   input wire logic rxEnable,
   // Transmit descriptors
   input wire logic txDescHost,
   input wire logic txDescIoc,
   input wire logic jabberExpire,
   output logic txDescWbValid,
   output logic [31:0] txDescWbBits,
   // Transmit data from memory
   input wire logic memTxValid,
   input wire logic [31:0] memTxData,
   input wire logic memTxLast,
   output logic memTxReady,
   // Transmit data to MAC
   output logic macTxValid,
   output logic [31:0] macTxData,
   output logic macTxLast,
   input wire logic macTxReady,
   // Receive side
   input wire logic rxDescHost,
   input wire logic rxCurDescDma,
   input wire logic rxFrameAccepted,
   input wire logic rxByteStrobe,
   input wire logic rxFrameEnd,
   input wire logic rxOverflowEvt,
   output logic rxDescWbValid,
   output logic [31:0] rxDescWbBits,
   // Process states
   output logic [2:0] txProcessState,
   output logic [2:0] rxProcessState
);
   eds_pkg::eds_tx_state_t txState_ff;
   eds_pkg::eds_tx_state_t nxt_txState;
   eds_pkg::eds_rx_state_t rxState_ff;
   eds_pkg::eds_rx_state_t nxt_rxState;
   logic [10:0] flags_ff;
   logic [10:0] evt;
   logic [10:0] clr;
   logic [16:0] enable_ff;
   logic abnSum_ff;
   logic nrmSum_ff;
   logic [31:0] regRdata_ff;
   logic txDescWbValid_ff;
   logic [31:0] txDescWbBits_ff;
   logic rxDescWbValid_ff;
   logic [31:0] rxDescWbBits_ff;
   logic rxDonePend_ff;
   logic [11:0] rxBytes_ff;
   logic txPoll;
   logic rxPoll;
   logic txUnderflow;
   logic outLast;
   logic inFrameOut_ff;
   logic wdogEvt;

   eds_stream_if #(.WIDTH(33)) fifoIn ();
   eds_stream_if #(.WIDTH(33)) fifoOut ();

   assign txPoll = regWrite && (regAddr == eds_pkg::OFF_TX_POLL);
   assign rxPoll = regWrite && (regAddr == eds_pkg::OFF_RX_POLL);
   assign clr = (regWrite && regAddr == eds_pkg::OFF_STATUS) ?
                regWdata[10:0] : 11'h000;

   // Transmit data path
   assign fifoIn.valid = memTxValid;
   assign fifoIn.data = {memTxLast, memTxData};
   assign memTxReady = fifoIn.ready;
   assign fifoOut.ready = macTxReady;
   assign macTxValid = fifoOut.valid;
   assign macTxData = fifoOut.data[31:0];
   assign macTxLast = fifoOut.data[32];
   assign outLast = fifoOut.valid && macTxReady && fifoOut.data[32];

   eds_fifo #(.WIDTH(33), .DEPTH(eds_pkg::FIFO_DEPTH)) txFifo (
      .clk(clk),
      .srst(srst),
      .allowIn(nxt_txState == eds_pkg::TX_READ),
      .inPort(fifoIn),
      .outPort(fifoOut)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         inFrameOut_ff <= 1'b0;
      end else if (fifoOut.valid && macTxReady) begin
         inFrameOut_ff <= !fifoOut.data[32];
      end
   end
   assign txUnderflow = inFrameOut_ff && macTxReady && !fifoOut.valid &&
                        txState_ff == eds_pkg::TX_READ;

   // Transmit process
   always_comb begin
      nxt_txState = txState_ff;
      unique case (txState_ff)
         eds_pkg::TX_STOP: if (txEnable) nxt_txState = eds_pkg::TX_FETCH;
         eds_pkg::TX_FETCH: begin
            nxt_txState = txDescHost ? eds_pkg::TX_SUSP : eds_pkg::TX_READ;
         end
         eds_pkg::TX_READ: begin
            if (txUnderflow) nxt_txState = eds_pkg::TX_SUSP;
            else if (outLast) nxt_txState = eds_pkg::TX_CLOSE;
         end
         eds_pkg::TX_SUSP: if (txPoll) nxt_txState = eds_pkg::TX_FETCH;
         eds_pkg::TX_CLOSE: nxt_txState = eds_pkg::TX_FETCH;
      endcase
      if (jabberExpire || !txEnable) nxt_txState = eds_pkg::TX_STOP;
   end

   always_ff @(posedge clk) begin
      if (srst) txState_ff <= eds_pkg::TX_STOP;
      else txState_ff <= nxt_txState;
   end

   // Transmit descriptor status writeback
   always_ff @(posedge clk) begin
      if (srst) begin
         txDescWbValid_ff <= 1'b0;
         txDescWbBits_ff <= 32'h0000_0000;
      end else begin
         txDescWbValid_ff <= jabberExpire || txUnderflow;
         txDescWbBits_ff <= 32'h0000_0000;
         txDescWbBits_ff[eds_pkg::DESC_JABBER_BIT] <= jabberExpire;
         txDescWbBits_ff[eds_pkg::DESC_UNF_BIT] <= txUnderflow;
      end
   end

   // Receive process
   always_comb begin
      nxt_rxState = rxState_ff;
      unique case (rxState_ff)
         eds_pkg::RX_STOP: if (rxEnable) nxt_rxState = eds_pkg::RX_FETCH;
         eds_pkg::RX_FETCH: begin
            nxt_rxState = rxDescHost ? eds_pkg::RX_SUSP : eds_pkg::RX_WAIT;
         end
         eds_pkg::RX_WAIT: if (rxFrameAccepted) nxt_rxState = eds_pkg::RX_XFER;
         eds_pkg::RX_SUSP: begin
            if (rxPoll || rxFrameAccepted) nxt_rxState = eds_pkg::RX_FETCH;
         end
         eds_pkg::RX_XFER: begin
            if (rxFrameEnd || rxOverflowEvt) nxt_rxState = eds_pkg::RX_FETCH;
         end
      endcase
      if (!rxEnable) nxt_rxState = eds_pkg::RX_STOP;
   end

   always_ff @(posedge clk) begin
      if (srst) rxState_ff <= eds_pkg::RX_STOP;
      else rxState_ff <= nxt_rxState;
   end

   // Received length counter for the watchdog
   always_ff @(posedge clk) begin
      if (srst || rxState_ff != eds_pkg::RX_XFER) begin
         rxBytes_ff <= 12'h000;
      end else if (rxByteStrobe && rxBytes_ff <= eds_pkg::RX_WDOG_BYTES) begin
         rxBytes_ff <= rxBytes_ff + 12'h001;
      end
   end
   assign wdogEvt = rxState_ff == eds_pkg::RX_XFER && rxByteStrobe &&
                    rxBytes_ff == eds_pkg::RX_WDOG_BYTES;

   // Receive descriptor status writeback
   always_ff @(posedge clk) begin
      if (srst) begin
         rxDescWbValid_ff <= 1'b0;
         rxDescWbBits_ff <= 32'h0000_0000;
         rxDonePend_ff <= 1'b0;
      end else begin
         rxDescWbValid_ff <= rxState_ff == eds_pkg::RX_XFER &&
            (rxFrameEnd || (rxOverflowEvt && rxBytes_ff != 12'h000));
         rxDescWbBits_ff <= 32'h0000_0000;
         rxDescWbBits_ff[eds_pkg::DESC_OVF_BIT] <= rxOverflowEvt &&
            rxBytes_ff != 12'h000;
         rxDonePend_ff <= rxState_ff == eds_pkg::RX_XFER && rxFrameEnd &&
                          !rxOverflowEvt;
      end
   end

   // Flag events
   always_comb begin
      evt = 11'h000;
      evt[eds_pkg::BIT_TX_DONE] = outLast && txDescIoc;
      evt[eds_pkg::BIT_TX_STOP] = nxt_txState == eds_pkg::TX_STOP &&
                                  txState_ff != eds_pkg::TX_STOP;
      evt[eds_pkg::BIT_TX_UNAV] = txState_ff == eds_pkg::TX_FETCH &&
                                  txDescHost;
      evt[eds_pkg::BIT_JABBER] = jabberExpire;
      evt[eds_pkg::BIT_RX_OVF] = rxOverflowEvt;
      evt[eds_pkg::BIT_TX_UNF] = txUnderflow;
      evt[eds_pkg::BIT_RX_DONE] = rxDonePend_ff;
      evt[eds_pkg::BIT_RX_UNAV] = rxState_ff == eds_pkg::RX_FETCH &&
                                  rxDescHost && rxCurDescDma;
      evt[eds_pkg::BIT_RX_STOP] = nxt_rxState == eds_pkg::RX_STOP &&
                                  rxState_ff != eds_pkg::RX_STOP;
      evt[eds_pkg::BIT_RX_WDOG] = wdogEvt;
      evt[eds_pkg::BIT_TX_EARLY] = fifoIn.valid && fifoIn.ready &&
                                   memTxLast;
   end

   always_ff @(posedge clk) begin
      if (srst) flags_ff <= eds_pkg::FLAGS_RESET;
      else flags_ff <= (flags_ff & ~clr) | evt;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         abnSum_ff <= 1'b0;
         nrmSum_ff <= 1'b0;
      end else begin
         abnSum_ff <= |(flags_ff & enable_ff[10:0] & eds_pkg::ABN_MASK);
         nrmSum_ff <= |(flags_ff & enable_ff[10:0] & eds_pkg::NRM_MASK);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) enable_ff <= eds_pkg::ENABLE_RESET;
      else if (regWrite && regAddr == eds_pkg::OFF_ENABLE)
         enable_ff <= regWdata[16:0];
   end

   // Register read
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata_ff <= 32'h0000_0000;
      end else begin
         regRdata_ff <= 32'h0000_0000;
         if (regRead && regAddr == eds_pkg::OFF_STATUS) begin
            regRdata_ff[10:0] <= flags_ff;
            regRdata_ff[eds_pkg::BIT_ABN_SUM] <= abnSum_ff;
            regRdata_ff[eds_pkg::BIT_NRM_SUM] <= nrmSum_ff;
            regRdata_ff[eds_pkg::RX_STATE_LSB +: 3] <= rxState_ff;
            regRdata_ff[eds_pkg::TX_STATE_LSB +: 3] <= txState_ff;
         end else if (regRead && regAddr == eds_pkg::OFF_ENABLE) begin
            regRdata_ff[16:0] <= enable_ff;
         end
      end
   end

   assign regRdata = regRdata_ff;
   assign txDescWbValid = txDescWbValid_ff;
   assign txDescWbBits = txDescWbBits_ff;
   assign rxDescWbValid = rxDescWbValid_ff;
   assign rxDescWbBits = rxDescWbBits_ff;
   assign txProcessState = txState_ff;
   assign rxProcessState = rxState_ff;

   // Checks
   sequence txHostSeen_s;
      txState_ff == eds_pkg::TX_FETCH && txDescHost && txEnable && !jabberExpire;
   endsequence
   sequence txSuspended_s;
      flags_ff[eds_pkg::BIT_TX_UNAV] && txState_ff == eds_pkg::TX_SUSP;
   endsequence

   tx_done_flag_a: assert property (@(posedge clk) disable iff (srst)
      outLast && txDescIoc |=> flags_ff[eds_pkg::BIT_TX_DONE])
      else $error("tx done flag not set");
   tx_stop_flag_a: assert property (@(posedge clk) disable iff (srst)
      txState_ff != eds_pkg::TX_STOP && !txEnable
      |=> flags_ff[eds_pkg::BIT_TX_STOP] && txState_ff == eds_pkg::TX_STOP)
      else $error("tx stop not flagged");
   tx_unav_susp_a: assert property (@(posedge clk) disable iff (srst)
      txHostSeen_s |=> txSuspended_s ##0 txProcessState == 3'h6)
      else $error("tx suspend not flagged");
   jabber_stop_a: assert property (@(posedge clk) disable iff (srst)
      jabberExpire |=> txState_ff == eds_pkg::TX_STOP && txDescWbValid &&
      txDescWbBits[eds_pkg::DESC_JABBER_BIT] && flags_ff[eds_pkg::BIT_JABBER])
      else $error("jabber handling wrong");
   underflow_susp_a: assert property (@(posedge clk) disable iff (srst)
      txUnderflow && !jabberExpire && txEnable |=> txProcessState == 3'h6 &&
      txDescWbBits[eds_pkg::DESC_UNF_BIT] && flags_ff[eds_pkg::BIT_TX_UNF])
      else $error("underflow handling wrong");
   rx_done_flag_a: assert property (@(posedge clk) disable iff (srst)
      rxDescWbValid && !rxDescWbBits[eds_pkg::DESC_OVF_BIT]
      |-> flags_ff[eds_pkg::BIT_RX_DONE] || evt[eds_pkg::BIT_RX_DONE])
      else $error("rx done flag missing");
   rx_unav_owner_a: assert property (@(posedge clk) disable iff (srst)
      $rose(flags_ff[eds_pkg::BIT_RX_UNAV]) |-> $past(rxCurDescDma))
      else $error("rx unavailable set with host current desc");
   rx_wdog_flag_a: assert property (@(posedge clk) disable iff (srst)
      wdogEvt |=> flags_ff[eds_pkg::BIT_RX_WDOG] ##1 rxBytes_ff != 12'h800 ||
      rxState_ff != eds_pkg::RX_XFER || !$past(rxByteStrobe))
      else $error("watchdog flag wrong");
   w1c_clear_a: assert property (@(posedge clk) disable iff (srst)
      clr[eds_pkg::BIT_RX_OVF] && !rxOverflowEvt
      |=> !flags_ff[eds_pkg::BIT_RX_OVF])
      else $error("write one did not clear");
   abn_sum_a: assert property (@(posedge clk) disable iff (srst)
      |(flags_ff & enable_ff[10:0] & eds_pkg::ABN_MASK) |=> abnSum_ff)
      else $error("abnormal summary missing");
endmodule : eth_dma_status_flags

// [tb/eds_host_model.sv]
// Behavioural host memory and MAC sink for the DMA event status block
`timescale 1ns/10ps
module eds_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Word stream from memory
   output logic memTxValid,
   output logic [31:0] memTxData,
   output logic memTxLast,
   input wire logic memTxReady,
   // Word stream into the MAC
   input wire logic macTxValid,
   input wire logic [31:0] macTxData,
   input wire logic macTxLast,
   output logic macTxReady,
   // Bench control
   input wire logic macStall
);
   logic [32:0] sendQ[$];
   logic [32:0] gotQ[$];
   int acceptCount = 0;
   assign macTxReady = !macStall;
   always @(posedge clk) begin
      if (macTxValid && macTxReady)
         gotQ.push_back({macTxLast, macTxData});
      if (memTxValid && memTxReady)
         acceptCount++;
      if (srst) begin
         memTxValid <= 1'h0;
         memTxLast <= 1'h0;
         memTxData <= 32'h0;
      end else if (!memTxValid || memTxReady) begin
         if (sendQ.size() > 0) begin
            {memTxLast, memTxData} <= sendQ.pop_front();
            memTxValid <= 1'h1;
         end else begin
            // Released lines carry a changing pattern
            memTxValid <= 1'h0;
            memTxLast <= 1'h0;
            memTxData <= ~memTxData;
         end
      end
   end
endmodule : eds_host_model

// [tb/tb_top.sv]
// Self-checking testbench for the DMA event status block
`timescale 1ns/10ps
module tb_top;
   localparam logic [15:0] ST = eds_pkg::OFF_STATUS;
   localparam logic [31:0] TXS = 32'h700000;
   localparam logic [31:0] RXS = 32'he0000;
   logic clk = 1'h0, srst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
   logic [15:0] regAddr = 16'h0;
   logic [31:0] regWdata = 32'h0, regRdata, txDescWbBits, rxDescWbBits;
   logic [31:0] macTxData, memTxData, txWb = 32'h0, rxWb = 32'h0, m;
   logic txEnable = 1'h0, rxEnable = 1'h0, txDescHost = 1'h0;
   logic txDescIoc = 1'h1, jabberExpire = 1'h0, rxDescHost = 1'h0;
   logic rxCurDescDma = 1'h0, rxFrameAccepted = 1'h0, rxByteStrobe = 1'h0;
   logic rxFrameEnd = 1'h0, rxOverflowEvt = 1'h0, macStall = 1'h1;
   logic txDescWbValid, rxDescWbValid, memTxValid, memTxLast, memTxReady;
   logic macTxValid, macTxLast, macTxReady;
   logic [2:0] txProcessState, rxProcessState;
   logic [32:0] w, expQ[$];
   int errors = 0, check_count = 0, cycles = 0;
   always #50 clk = ~clk;
   eth_dma_status_flags i_eth_dma_status_flags (.clk, .srst, .regAddr,
      .regWdata, .regWrite, .regRead, .regRdata, .txEnable, .rxEnable,
      .txDescHost, .txDescIoc, .jabberExpire, .txDescWbValid, .txDescWbBits,
      .memTxValid, .memTxData, .memTxLast, .memTxReady, .macTxValid,
      .macTxData, .macTxLast, .macTxReady, .rxDescHost, .rxCurDescDma,
      .rxFrameAccepted, .rxByteStrobe, .rxFrameEnd, .rxOverflowEvt,
      .rxDescWbValid, .rxDescWbBits, .txProcessState, .rxProcessState);
   eds_host_model i_eds_host_model (.clk, .srst, .memTxValid, .memTxData,
      .memTxLast, .memTxReady, .macTxValid, .macTxData, .macTxLast,
      .macTxReady, .macStall);
   function automatic logic [31:0] bitm(input int k);
      return 32'h1 << k;
   endfunction : bitm
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic regWr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'h1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask : regWr
   task automatic rdChk(input logic [15:0] a, input logic [31:0] k, e,
                        input string what);
      @(posedge clk);
      regRead <= 1'h1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'h0;
      @(negedge clk);
      chk(what, e, regRdata & k);
      @(posedge clk);
   endtask : rdChk
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: rxFrameAccepted <= 1'h1;
         1: rxFrameEnd <= 1'h1;
         2: rxOverflowEvt <= 1'h1;
         default: jabberExpire <= 1'h1;
      endcase
      @(posedge clk);
      {rxFrameAccepted, rxFrameEnd, rxOverflowEvt, jabberExpire} <= 4'h0;
   endtask : pulse
   task automatic rxFrame(input int n, input bit ovf);
      pulse(0);
      repeat (n) begin
         @(posedge clk);
         rxByteStrobe <= 1'h1;
         @(posedge clk);
         rxByteStrobe <= 1'h0;
      end
      if (ovf)
         pulse(2);
      pulse(1);
      repeat (4) @(posedge clk);
   endtask : rxFrame
   always @(posedge clk) begin
      cycles++;
      if (txDescWbValid)
         txWb <= txDescWbBits;
      if (rxDescWbValid)
         rxWb <= rxDescWbBits;
      if (cycles == 30000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      m = $urandom(59581);
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      rdChk(ST, 32'hffffffff, 32'h0, "status reset");
      rdChk(eds_pkg::OFF_ENABLE, 32'hffffffff, 32'h0, "enable reset");
      rdChk(16'h1ff0, 32'hffffffff, 32'h0, "unmapped read");
      regWr(eds_pkg::OFF_ENABLE, 32'h7ff);
      rdChk(eds_pkg::OFF_ENABLE, 32'h1ffff, 32'h7ff, "enable readback");
      txDescHost <= 1'h1;
      txEnable <= 1'h1;
      repeat (10) @(posedge clk);
      rdChk(ST, TXS | bitm(2) | bitm(16), 32'h600000 | bitm(2) | bitm(16),
            "tx suspended");
      txDescHost <= 1'h0;
      regWr(eds_pkg::OFF_TX_POLL, 32'h0);
      regWr(ST, 32'h7ff);
      repeat (5) @(posedge clk);
      rdChk(ST, TXS | 32'h7ff, 32'h300000, "tx resumed");
      for (int i = 0; i < 20; i++) begin
         w = {i == 19, $urandom()};
         expQ.push_back(w);
         i_eds_host_model.sendQ.push_back(w);
      end
      repeat (60) @(posedge clk);
      chk("fifo fill", 32'd17, i_eds_host_model.acceptCount);
      rdChk(ST, bitm(0) | bitm(10), 32'h0, "flags before drain");
      macStall <= 1'h0;
      for (int k = 0; k < 300 && i_eds_host_model.gotQ.size() < 20; k++)
         @(posedge clk);
      chk("words out", 32'd20, i_eds_host_model.gotQ.size());
      foreach (expQ[i]) begin
         chk("mac word", expQ[i][31:0], i_eds_host_model.gotQ[i][31:0]);
         chk("mac last", {31'h0, expQ[i][32]},
             {31'h0, i_eds_host_model.gotQ[i][32]});
      end
      rdChk(ST, 32'h187ff, 32'h18401, "frame sent");
      regWr(ST, 32'h0);
      m = $urandom() & 32'h401;
      regWr(ST, m);
      rdChk(ST, 32'h7ff, 32'h401 & ~m, "partial clear");
      regWr(ST, 32'hffffffff);
      rdChk(ST, 32'h187ff, 32'h0, "summaries clear");
      txDescIoc <= 1'h0;
      i_eds_host_model.sendQ.push_back({1'h1, $urandom()});
      repeat (20) @(posedge clk);
      rdChk(ST, 32'h401, bitm(10), "frame no request");
      regWr(ST, 32'h7ff);
      txDescIoc <= 1'h1;
      for (int i = 0; i < 3; i++)
         i_eds_host_model.sendQ.push_back({1'h0, $urandom()});
      repeat (30) @(posedge clk);
      rdChk(ST, TXS | bitm(5), 32'h600000 | bitm(5), "underflow");
      chk("tx desc underflow", 32'h2, txWb & 32'h2);
      pulse(3);
      txEnable <= 1'h0;
      repeat (5) @(posedge clk);
      rdChk(ST, TXS | 32'ha | bitm(15), 32'ha | bitm(15),
            "jabber");
      chk("tx desc jabber", 32'h4000, txWb & 32'h4000);
      chk("tx state pin", 32'h0, {29'h0, txProcessState});
      rxEnable <= 1'h1;
      repeat (5) @(posedge clk);
      rdChk(ST, RXS, 32'h60000, "rx waiting");
      regWr(ST, 32'h7ff);
      rxFrame(2048, 1'b0);
      rdChk(ST, 32'h250, bitm(6), "rx 2048 bytes");
      regWr(ST, 32'h7ff);
      rxFrame(2049, 1'b0);
      rdChk(ST, bitm(9), bitm(9), "rx 2049 bytes");
      regWr(ST, 32'h7ff);
      rxDescHost <= 1'h1;
      rxCurDescDma <= 1'h1;
      rxFrame(1, 1'b1);
      chk("rx desc overflow", 32'h800, rxWb & 32'h800);
      rdChk(ST, RXS | 32'h90, 32'h80000 | 32'h90, "rx suspend");
      rxDescHost <= 1'h0;
      pulse(0);
      repeat (5) @(posedge clk);
      rdChk(ST, RXS, 32'h60000, "rx resumed");
      rxDescHost <= 1'h1;
      rxFrame(1, 1'b0);
      rxDescHost <= 1'h0;
      regWr(eds_pkg::OFF_RX_POLL, 32'h0);
      repeat (3) @(posedge clk);
      rdChk(ST, RXS, 32'h60000, "rx poll resumed");
      chk("rx state pin", 32'h3, {29'h0, rxProcessState});
      rxEnable <= 1'h0;
      repeat (5) @(posedge clk);
      rdChk(ST, RXS | bitm(8), bitm(8), "rx stopped");
      report_and_stop();
   end
endmodule : tb_top
